/* File: verilog/utxd_pkg.sv */
// Constants and register map for the transmit path with DMA select
package utxd_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] UTXD_ADDR_DATA = 3'h0;
  localparam logic [2:0] UTXD_ADDR_CTRL = 3'h1;
  localparam logic [2:0] UTXD_ADDR_DMA_SEL = 3'h2;
  localparam logic [2:0] UTXD_ADDR_STATUS = 3'h3;
  localparam logic [2:0] UTXD_ADDR_BAUD = 3'h4;
  // Control register fields
  localparam int UTXD_CTRL_TX_ON = 0;
  localparam int UTXD_CTRL_NINE = 1;
  localparam int UTXD_CTRL_TWO_STOP = 2;
  localparam int UTXD_CTRL_POL_FLIP = 3;
  localparam int UTXD_CTRL_NINTH_BIT = 4;
  localparam int UTXD_CTRL_TX_EMPTY_IRQ = 5;
  localparam int UTXD_CTRL_RX_FULL_IRQ = 6;
  localparam int UTXD_CTRL_TX_DONE_IRQ = 7;
  // DMA select fields
  localparam int UTXD_DMA_TX_SEL = 7;
  localparam int UTXD_DMA_RX_SEL = 5;
  localparam logic [7:0] UTXD_DMA_SEL_MASK = 8'hA0;
  // Status fields
  localparam int UTXD_STAT_TX_FREE = 7;
  localparam int UTXD_STAT_TX_DONE = 6;
  localparam int UTXD_STAT_RX_FULL = 5;
  localparam int UTXD_STAT_TX_PIN_OWNED = 4;
  // Reset values
  localparam logic [7:0] UTXD_CTRL_RESET = 8'h00;
  localparam logic [7:0] UTXD_DMA_SEL_RESET = 8'h00;
  localparam logic [12:0] UTXD_BAUD_RESET = 13'h0004;
  // Frame base length in bits, oversample count, counter steps, idle frame
  localparam logic [3:0] UTXD_FRAME_BASE = 4'hA;
  localparam logic [3:0] UTXD_OVERSAMPLE = 4'hF;
  localparam logic [12:0] UTXD_BAUD_ONE = 13'h0001;
  localparam logic [3:0] UTXD_BIT_ONE = 4'h1;
  localparam logic [11:0] UTXD_IDLE_FRAME = 12'hFFF;

  typedef enum logic [2:0] {
    UTXD_OFF = 3'b001,
    UTXD_IDLE = 3'b010,
    UTXD_SHIFT = 3'b100
  } utxd_state_e;
endpackage

/* File: verilog/utxd_top.sv */
// Transmit path, shared baud generator and interrupt or DMA request select
//
// Operation
// - Tx free plus enable: irq or DMA by bit7
// - Tx empty enable clear blocks both requests
// - Rx full plus enable: irq or DMA by bit5
// - Rx full enable clear blocks both requests
// - DMA select bits 6,4,3,2-0 read zero
// - Full duplex, one shared baud generator
// - Baud generator runs on bus clock
// - Receive timing realigns on falling edges
// - Polarity flip clear at reset, idle high
// - Enabling sends one idle preamble frame
// - Data write buffers character, else stay idle
// - Shift register 10, 11 or 12 bits
// - Default frame start, eight data, one stop
// - Buffer moves to shifter on tick, flag sets
// - Empty after stop sets done, output high
// - Tx off waits for the shifter frame to finish, buffer not sent
// - Start 0, data lsb first, stop 1
// - Polarity flip covers every output level
// - Ninth bit loaded with data in nine-bit mode
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
module utxd_top
  import utxd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic rx_buffer_full_flag,
  output logic rx_sample_tick,
  output logic baud_tick,
  output logic txd_out,
  output logic txd_oe,
  output logic tx_irq_req,
  output logic tx_dma_req,
  output logic rx_irq_req,
  output logic rx_dma_req,
  output logic tx_done_irq_req
);
  import utxd_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    utxd_state_e state;
    logic [7:0] ctrl;
    logic [7:0] dma_sel;
    logic [12:0] baud_div;
    logic [12:0] baud_cnt;
    logic [3:0] os_cnt;
    logic [11:0] shifter;
    logic [3:0] bits_left;
    logic [8:0] buf_data;
    logic buf_full;
    logic tx_done;
    logic preamble_due;
    logic [7:0] rdata;
    logic rx_tick;
    logic bit_tick;
    logic txd;
    logic oe;
    logic tx_irq;
    logic tx_dma;
    logic rx_irq;
    logic rx_dma;
    logic done_irq;
  } utxd_regs_s;

  utxd_regs_s q_r;
  utxd_regs_s q_nxt;

  // Frame length grows by one for nine-bit data and one for a second stop
  function automatic logic [3:0] frame_len(input logic [7:0] c);
    frame_len = UTXD_FRAME_BASE + {3'h0, c[UTXD_CTRL_NINE]}
      + {3'h0, c[UTXD_CTRL_TWO_STOP]};
  endfunction

  // Frame image, sent from bit 0: start, data lsb first, stops
  function automatic logic [11:0] frame_img(input logic [7:0] c, input logic [8:0] d);
    logic [11:0] f;
    f = UTXD_IDLE_FRAME;
    if (c[UTXD_CTRL_NINE]) begin
      f[9:0] = {d, 1'b0};
    end else begin
      f[8:0] = {d[7:0], 1'b0};
    end
    frame_img = f;
  endfunction

  logic tx_free;

  always_comb begin
    q_nxt = q_r;
    tx_free = !q_r.buf_full;
    q_nxt.rx_tick = 1'b0;
    q_nxt.bit_tick = 1'b0;

    // ****************************************
    // Baud generator, bus clock, 16x ticks
    // ****************************************
    // One divider feeds both directions; the receiver realigns on its own edges
    if (q_r.baud_cnt <= UTXD_BAUD_ONE) begin
      q_nxt.baud_cnt = q_r.baud_div;
      q_nxt.rx_tick = 1'b1;
      q_nxt.os_cnt = q_r.os_cnt + UTXD_BIT_ONE;
      if (q_r.os_cnt == UTXD_OVERSAMPLE) begin
        q_nxt.bit_tick = 1'b1;
      end
    end else begin
      q_nxt.baud_cnt = q_r.baud_cnt - UTXD_BAUD_ONE;
    end

    // ****************************************
    // Register port
    // ****************************************
    q_nxt.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        UTXD_ADDR_CTRL: q_nxt.rdata = q_r.ctrl;
        UTXD_ADDR_DMA_SEL: q_nxt.rdata = q_r.dma_sel & UTXD_DMA_SEL_MASK;
        UTXD_ADDR_STATUS: begin
          q_nxt.rdata[UTXD_STAT_TX_FREE] = tx_free;
          q_nxt.rdata[UTXD_STAT_TX_DONE] = q_r.tx_done;
          q_nxt.rdata[UTXD_STAT_RX_FULL] = rx_buffer_full_flag;
          q_nxt.rdata[UTXD_STAT_TX_PIN_OWNED] = q_r.oe;
        end
        UTXD_ADDR_BAUD: q_nxt.rdata = q_r.baud_div[7:0];
        default: q_nxt.rdata = 8'h00;
      endcase
    end
    if (reg_wr) begin
      unique case (reg_addr)
        UTXD_ADDR_DATA: begin
          // Write while full overwrites the waiting character
          q_nxt.buf_data = {q_r.ctrl[UTXD_CTRL_NINTH_BIT], reg_wdata};
          q_nxt.buf_full = 1'b1;
          q_nxt.tx_done = 1'b0;
        end
        UTXD_ADDR_CTRL: begin
          q_nxt.ctrl = reg_wdata;
          if (reg_wdata[UTXD_CTRL_TX_ON] && !q_r.ctrl[UTXD_CTRL_TX_ON]) begin
            q_nxt.preamble_due = 1'b1;
          end
        end
        UTXD_ADDR_DMA_SEL: q_nxt.dma_sel = reg_wdata & UTXD_DMA_SEL_MASK;
        UTXD_ADDR_BAUD: q_nxt.baud_div = {5'h00, reg_wdata};
        default: ;
      endcase
    end

    // ****************************************
    // Transmitter
    // ****************************************
    unique case (q_r.state)
      UTXD_OFF: begin
        q_nxt.oe = 1'b0;
        if (q_r.ctrl[UTXD_CTRL_TX_ON]) begin
          q_nxt.state = UTXD_IDLE;
          q_nxt.oe = 1'b1;
        end
      end
      UTXD_IDLE: begin
        if (q_r.bit_tick) begin
          if (q_r.preamble_due && q_r.ctrl[UTXD_CTRL_TX_ON]) begin
            q_nxt.shifter = UTXD_IDLE_FRAME;
            q_nxt.bits_left = frame_len(q_r.ctrl);
            q_nxt.preamble_due = 1'b0;
            q_nxt.state = UTXD_SHIFT;
          end else if (q_r.buf_full && q_r.ctrl[UTXD_CTRL_TX_ON]) begin
            q_nxt.shifter = frame_img(q_r.ctrl, q_r.buf_data);
            q_nxt.bits_left = frame_len(q_r.ctrl);
            q_nxt.buf_full = reg_wr && reg_addr == UTXD_ADDR_DATA;
            q_nxt.state = UTXD_SHIFT;
          end else if (!q_r.ctrl[UTXD_CTRL_TX_ON]) begin
            q_nxt.state = UTXD_OFF;
            q_nxt.oe = 1'b0;
          end
        end
      end
      UTXD_SHIFT: begin
        if (q_r.bit_tick) begin
          q_nxt.shifter = {1'b1, q_r.shifter[11:1]};
          q_nxt.bits_left = q_r.bits_left - UTXD_BIT_ONE;
          if (q_r.bits_left == UTXD_BIT_ONE) begin
            // Stop bit finished; pin stays driven until idle decides to release
            q_nxt.state = UTXD_IDLE;
            // A data write on this very edge keeps done clear
            if (!q_nxt.buf_full) begin
              q_nxt.tx_done = 1'b1;
            end
          end
        end
      end
      default: q_nxt.state = UTXD_OFF;
    endcase

    // ****************************************
    // Pin drive and request select
    // ****************************************
    q_nxt.txd = ((q_nxt.state == UTXD_SHIFT) ? q_nxt.shifter[0] : 1'b1)
      ^ q_nxt.ctrl[UTXD_CTRL_POL_FLIP];
    q_nxt.tx_irq = q_nxt.ctrl[UTXD_CTRL_TX_EMPTY_IRQ] && !q_nxt.buf_full
      && !q_nxt.dma_sel[UTXD_DMA_TX_SEL];
    q_nxt.tx_dma = q_nxt.ctrl[UTXD_CTRL_TX_EMPTY_IRQ] && !q_nxt.buf_full
      && q_nxt.dma_sel[UTXD_DMA_TX_SEL];
    q_nxt.rx_irq = q_nxt.ctrl[UTXD_CTRL_RX_FULL_IRQ] && rx_buffer_full_flag
      && !q_nxt.dma_sel[UTXD_DMA_RX_SEL];
    q_nxt.rx_dma = q_nxt.ctrl[UTXD_CTRL_RX_FULL_IRQ] && rx_buffer_full_flag
      && q_nxt.dma_sel[UTXD_DMA_RX_SEL];
    // Software keeps this enable clear while transmit DMA is in use
    q_nxt.done_irq = q_nxt.ctrl[UTXD_CTRL_TX_DONE_IRQ] && q_nxt.tx_done;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q_r <= '{state: UTXD_OFF, ctrl: UTXD_CTRL_RESET, dma_sel: UTXD_DMA_SEL_RESET,
        baud_div: UTXD_BAUD_RESET, baud_cnt: UTXD_BAUD_RESET, os_cnt: 4'h0,
        shifter: UTXD_IDLE_FRAME, bits_left: 4'h0, buf_data: 9'h000, buf_full: 1'b0,
        tx_done: 1'b1, preamble_due: 1'b0, rdata: 8'h00, rx_tick: 1'b0,
        bit_tick: 1'b0, txd: 1'b1, oe: 1'b0, tx_irq: 1'b0, tx_dma: 1'b0,
        rx_irq: 1'b0, rx_dma: 1'b0, done_irq: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata = q_r.rdata;
  assign rx_sample_tick = q_r.rx_tick;
  assign baud_tick = q_r.bit_tick;
  assign txd_out = q_r.txd;
  assign txd_oe = q_r.oe;
  assign tx_irq_req = q_r.tx_irq;
  assign tx_dma_req = q_r.tx_dma;
  assign rx_irq_req = q_r.rx_irq;
  assign rx_dma_req = q_r.rx_dma;
  assign tx_done_irq_req = q_r.done_irq;
endmodule // utxd_top

/* File: tb/utxd_assertions.sv */
// Port-level checks for the transmit path and request select
`timescale 1ns/1ps
module utxd_checker
  import utxd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_buffer_full_flag,
  input wire logic baud_tick,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic tx_irq_req,
  input wire logic tx_dma_req,
  input wire logic rx_irq_req,
  input wire logic rx_dma_req,
  input wire logic rx_sample_tick,
  input wire logic tx_done_irq_req
);
  // ****************************************
  // Shadow of the three request enables
  // ****************************************
  logic [2:0] en_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      en_r <= 3'h0;
    else if (reg_wr && reg_addr == UTXD_ADDR_CTRL)
      en_r <= reg_wdata[7:5];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_tx_req_excl: assert property (!(tx_irq_req && tx_dma_req))
    else $error("tx irq and dma both high");
  a_rx_req_excl: assert property (!(rx_irq_req && rx_dma_req))
    else $error("rx irq and dma both high");
  a_tx_en_off: assert property (!en_r[0] && !$past(en_r[0]) |-> !tx_irq_req && !tx_dma_req)
    else $error("tx request without enable");
  a_rx_en_off: assert property (!en_r[1] && !$past(en_r[1]) |-> !rx_irq_req && !rx_dma_req)
    else $error("rx request without enable");
  a_rx_req_cause: assert property (rx_irq_req || rx_dma_req |-> $past(rx_buffer_full_flag))
    else $error("rx request without full flag");
  a_baud_tick_gap: assert property ($rose(baud_tick) |=> !baud_tick [*8])
    else $error("baud ticks too close");
  a_txd_bit_edge: assert property ($changed(txd_out) |-> $past(baud_tick) ||
    $past(baud_tick, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("txd changed off a bit boundary");
  a_oe_drop_tick: assert property ($fell(txd_oe) |-> $past(baud_tick) || $past(baud_tick, 2))
    else $error("pin released mid bit");
  a_dma_reserved: assert property ($past(reg_rd) && $past(reg_addr) == UTXD_ADDR_DMA_SEL
    |-> (reg_rdata & ~UTXD_DMA_SEL_MASK) == 8'h00)
    else $error("reserved dma select bits set");
  a_tick_align: assert property (baud_tick |-> rx_sample_tick)
    else $error("bit tick without sample tick");
  a_done_irq_en: assert property (!en_r[2] && !$past(en_r[2]) |-> !tx_done_irq_req)
    else $error("done request without enable");
endmodule // utxd_checker
bind utxd_top utxd_checker chk_i (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .rx_buffer_full_flag, .baud_tick, .txd_out, .txd_oe, .tx_irq_req, .tx_dma_req,
  .rx_irq_req, .rx_dma_req, .rx_sample_tick, .tx_done_irq_req);

/* File: tb/utxd_remote_model.sv */
// Remote serial receiver, eight data bits, one stop, own bit timer
`timescale 1ns/1ps
module utxd_remote_model #(
  parameter int BIT = 16
) (
  input wire logic ref_clk,
  input wire logic txd_out,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic frame_err
);
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    frame_err = 1'b0;
  end
  // Mid-bit sampling, start edge only, so a bad bit count shows
  always begin
    @(negedge txd_out);
    repeat (BIT / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge ref_clk);
      rx_byte[i] = txd_out;
    end
    repeat (BIT) @(posedge ref_clk);
    frame_err = (txd_out !== 1'b1);
    rx_valid = 1'b1;
    @(posedge ref_clk);
    rx_valid = 1'b0;
  end
endmodule // utxd_remote_model

/* File: tb/testbench.sv */
// Self-checking bench for the transmit path and request select
`timescale 1ns/1ps
module testbench;
  import utxd_pkg::*;
  logic ref_clk, resetn, reg_wr, reg_rd, rx_buffer_full_flag, rx_valid, frame_err;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_byte;
  logic txd_out, txd_oe, tx_irq_req, tx_dma_req, rx_irq_req, rx_dma_req, tx_done_irq_req;
  int failures, comparisons, n;
  utxd_top dut (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_buffer_full_flag, .rx_sample_tick(), .baud_tick(), .txd_out, .txd_oe, .tx_irq_req,
    .tx_dma_req, .rx_irq_req, .rx_dma_req, .tx_done_irq_req);
  utxd_remote_model #(.BIT(16)) peer (.ref_clk, .txd_out, .rx_byte, .rx_valid, .frame_err);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata & m, e);
  endtask
  task wait_byte(input logic [7:0] e);
    n = 0;
    while (rx_valid !== 1'b1 && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 600) begin
      failures++;
      results();
    end else begin
      chk(rx_byte, e);
      chk(frame_err, 8'h00);
    end
  endtask
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    rx_buffer_full_flag = 1'b1;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk(txd_out, 8'h01);
    rd(UTXD_ADDR_DMA_SEL, 8'hFF, 8'h00);
    wr(UTXD_ADDR_DMA_SEL, 8'hFF);
    rd(UTXD_ADDR_DMA_SEL, 8'hFF, 8'hA0);
    rd(3'h7, 8'hFF, 8'h00);
    $display("register test done");
    // Four requests checked over all 16 enable and select combinations
    for (int i = 0; i < 16; i++) begin
      wr(UTXD_ADDR_CTRL, {1'b0, i[1], i[0], 5'h00});
      wr(UTXD_ADDR_DMA_SEL, {i[2], 1'b0, i[3], 5'h00});
      repeat (3) @(negedge ref_clk);
      chk({tx_irq_req, tx_dma_req, rx_irq_req, rx_dma_req},
        {i[0] & !i[2], i[0] & i[2], i[1] & !i[3], i[1] & i[3]});
    end
    @(posedge ref_clk);
    rx_buffer_full_flag <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({rx_irq_req, rx_dma_req}, 8'h00);
    $display("request routing test done");
    wr(UTXD_ADDR_DMA_SEL, 8'h00);
    wr(UTXD_ADDR_BAUD, 8'h01);
    wr(UTXD_ADDR_CTRL, 8'h21);
    wr(UTXD_ADDR_DATA, 8'hA5);
    rd(UTXD_ADDR_STATUS, 8'h80, 8'h00);
    chk(tx_irq_req, 8'h00);
    wait_byte(8'hA5);
    repeat (20) @(negedge ref_clk);
    rd(UTXD_ADDR_STATUS, 8'hC0, 8'hC0);
    chk(txd_out, 8'h01);
    chk(tx_irq_req, 8'h01);
    wr(UTXD_ADDR_CTRL, 8'hA1);
    @(negedge ref_clk);
    chk(tx_done_irq_req, 8'h01);
    $display("frame test done");
    wr(UTXD_ADDR_DATA, 8'h3C);
    repeat (40) @(negedge ref_clk);
    wr(UTXD_ADDR_CTRL, 8'h00);
    chk(txd_oe, 8'h01);
    wait_byte(8'h3C);
    n = 0;
    while (txd_oe !== 1'b0 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk(txd_oe, 8'h00);
    $display("disable test done");
    wr(UTXD_ADDR_CTRL, 8'h08);
    repeat (3) @(negedge ref_clk);
    chk(txd_out, 8'h00);
    $display("polarity test done");
    results();
  end
endmodule // testbench
